// [hdl/rwcm_params.svh]
`ifndef RWCM_PARAMS_SVH
`define RWCM_PARAMS_SVH
// Register offsets
`define RWCM_OFS_OPTION 8'h39
`define RWCM_OFS_SERVICE 8'h3A
`define RWCM_OFS_STATUS 8'h3B
`define RWCM_OFS_TEST 8'h3E
`define RWCM_OFS_CONFIG 8'h3F
// Field positions
`define RWCM_B_IRQ_EDGE_SELECT 5
`define RWCM_B_DLY 4
`define RWCM_B_CME 3
`define RWCM_B_NOWD 2
`define RWCM_B_DISABLE_RESETS 0
// Reset values and service codes
`define RWCM_OPTION_RST 8'h10
`define RWCM_ARM_CODE 8'h55
`define RWCM_CLEAR_CODE 8'hAA
// Timing, counted in E-clock ticks
`define RWCM_POR_CYC 12'hFE0
`define RWCM_DRIVE_CYC 12'h004
`define RWCM_SETTLE_CYC 12'h002
`define RWCM_WIN_CYC 7'h40
`define RWCM_STOP_CYC 12'hFA0
`define RWCM_FAST_CYC 12'h004
`define RWCM_PRE_MAX 15'h7FFF
// Clock monitor gap: 50 us at an 8 ns system clock
`define RWCM_CLK_NS 8
`define RWCM_CM_GAP_NS 50000
`define RWCM_CM_GAP_CYC (`RWCM_CM_GAP_NS / `RWCM_CLK_NS)
// Reset vectors
`define RWCM_VEC_EXT_N 16'hFFFE
`define RWCM_VEC_CM_N 16'hFFFC
`define RWCM_VEC_WD_N 16'hFFFA
`define RWCM_VEC_EXT_S 16'hBFFE
`define RWCM_VEC_CM_S 16'hBFFC
`define RWCM_VEC_WD_S 16'hBFFA
`endif

// [hdl/rwcm_pkg.sv]
package rwcm_pkg;
	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rwcm_req_t;
	// Reset sequencer states
	typedef enum logic [2:0] {
		SQ_POR = 3'h0,
		SQ_DRIVE = 3'h1,
		SQ_SETTLE = 3'h2,
		SQ_HOLD = 3'h3,
		SQ_RUN = 3'h4
	} rwcm_seq_t;
	// Reset causes
	typedef enum logic [1:0] {
		CS_EXT = 2'h0,
		CS_CM = 2'h1,
		CS_WDOG = 2'h2
	} rwcm_cause_t;
	// Clock halt states
	typedef enum logic [1:0] {
		HS_RUN = 2'h0,
		HS_HALT = 2'h1,
		HS_EXIT = 2'h2
	} rwcm_halt_t;
endpackage : rwcm_pkg

// [hdl/rwcm_top.sv]
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "rwcm_params.svh"
// Overview of operation
// [R1] Protected option bits: once, first 64 cycles
// [R2] Option bits 7, 6, 2 read zero
// [R3] Irq edge select: 0 level, 1 edge
// [R4] Stop exit waits 4000 or four cycles
// [R5] Clock monitor resets only when enabled
// [R6] Watchdog: E over 2^15, then 1/4/16/64
// [R7] Reset clears watchdog rate select
// [R8] Four reset sources, three vectors
// [R9] Power-on holds 4064 cycles, then pin
// [R10] Drive reset pin low four cycles
// [R11] Sample pin two cycles after release; code decides on the third E tick after release
// [R12] External circuit must not slow pin rise
// [R13] Unserviced watchdog forces system reset
// [R14] Watchdog on out of reset; disable bit; code sets the disable bit in special mode
// [R15] Special modes: disable resets bit gates; code gates the watchdog only, not the monitor
// [R16] Write 55 to arm, AA to clear
// [R17] Monitor timeout runs independent of bus clock
// [R18] Below 10 kHz fails, 200 kHz passes
// [R19] Enabled monitor resets during clock halt
// [R20] Software clears monitor enable before halt
// [R21] Reset aborts, loads cause's vector
// [R22] Service register eight bits, resets zero
// [R23] Reset sets delay enable, clears monitor
// [R24] Vector addresses per mode and cause
// [R25] Unarmed AA write leaves counter alone
module rwcm_top #(
	parameter int CM_GAP_CYC = `RWCM_CM_GAP_CYC
) (
	input wire logic sys_clk_i, // System clock, 125 MHz
	input wire logic rst_i, // Power-on reset, async high
	input wire rwcm_pkg::rwcm_req_t req_i, // Register port request
	output logic [7:0] rdata_o, // Read data, cycle after read
	input wire logic e_tick_i, // One pulse per E-clock cycle
	input wire logic osc_ok_i, // Oscillator running, async
	input wire logic mode_special_i, // Special mode strap, async
	input wire logic rst_pin_i, // Reset pin level, async
	output logic rst_pin_o, // Reset pin drive value
	output logic rst_pin_oe_o, // Reset pin drive enable
	input wire logic irq_n_i, // Interrupt request pin, async
	input wire logic irq_ack_i, // CPU took edge interrupt
	output logic irq_req_o, // Interrupt request to CPU
	input wire logic halt_req_i, // CPU executes clock halt
	input wire logic wake_i, // Wake-up request, async
	output logic halted_o, // Clocks halted or restarting
	output logic cpu_reset_o, // CPU held in reset
	output logic [15:0] vector_o // Reset vector address
);
	// Pin synchronisers
	logic [4:0] sy1_reg;
	logic [4:0] sy2_reg;
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sy1_reg <= 5'h1F;
			sy2_reg <= 5'h1F;
		end else begin
			sy1_reg <= {osc_ok_i, mode_special_i, rst_pin_i, irq_n_i, wake_i};
			sy2_reg <= sy1_reg;
		end
	end
	wire osc_ok = sy2_reg[4];
	wire strap_special = sy2_reg[3];
	wire pin_low = ~sy2_reg[2];
	wire irq_low = ~sy2_reg[1];
	wire wake = sy2_reg[0];

	// State
	rwcm_pkg::rwcm_seq_t st_reg, st_next;
	rwcm_pkg::rwcm_cause_t cause_reg, cause_next;
	rwcm_pkg::rwcm_halt_t hs_reg, hs_next;
	logic [11:0] cnt_reg, cnt_next;
	logic [11:0] hcnt_reg, hcnt_next;
	logic [14:0] pre_reg, pre_next;
	logic [5:0] div_reg, div_next;
	logic [15:0] gap_reg, gap_next;
	logic [6:0] win_reg, win_next;
	logic special_reg, armed_reg, opt_once_reg, cfg_once_reg;
	logic irq_edge_select_reg, dly_reg, cme_reg, nowd_reg, disable_resets_reg, irq_pend_reg;
	logic [1:0] rate_reg;
	logic [7:0] svc_reg;

	// Clock ticks stop while halted; the exit delay needs the oscillator
	wire halted = (hs_reg == rwcm_pkg::HS_HALT);
	wire tick = e_tick_i & ~halted;
	wire running = (st_reg == rwcm_pkg::SQ_RUN);
	wire in_rst = ~running;

	// Register decode
	wire wr_opt = req_i.wr & (req_i.addr == `RWCM_OFS_OPTION);
	wire wr_svc = req_i.wr & (req_i.addr == `RWCM_OFS_SERVICE);
	wire wr_test = req_i.wr & (req_i.addr == `RWCM_OFS_TEST);
	wire wr_cfg = req_i.wr & (req_i.addr == `RWCM_OFS_CONFIG);
	wire win_open = (win_reg < `RWCM_WIN_CYC);
	wire opt_prot_ok = special_reg | (win_open & ~opt_once_reg); // R1
	wire cfg_prot_ok = special_reg | (win_open & ~cfg_once_reg);
	wire svc_arm = wr_svc & (req_i.wdata == `RWCM_ARM_CODE); // R16
	wire svc_clear = wr_svc & (req_i.wdata == `RWCM_CLEAR_CODE) & armed_reg; // R16 R25

	// Watchdog: prescaler then rate divider
	wire wd_en = running & ~nowd_reg & ~(special_reg & disable_resets_reg); // R14 R15
	wire pre_wrap = tick & (pre_reg == `RWCM_PRE_MAX); // R6
	logic [5:0] div_limit;
	always_comb begin
		unique case (rate_reg) // R6
			2'h0: div_limit = 6'h00;
			2'h1: div_limit = 6'h03;
			2'h2: div_limit = 6'h0F;
			2'h3: div_limit = 6'h3F;
		endcase
	end
	wire wd_fire = wd_en & pre_wrap & (div_reg == div_limit); // R13

	// Clock monitor: a gap in E ticks longer than the limit trips it.
	// The limit sits between the 5 us and 100 us periods, so clocks
	// above 200 kHz never trip and below 10 kHz always do.
	wire cm_fire = running & cme_reg & (gap_reg == 16'(CM_GAP_CYC - 1)); // R5 R17 R18 R19

	// Reset sequencer
	always_comb begin
		st_next = st_reg;
		cause_next = cause_reg;
		cnt_next = cnt_reg;
		unique case (st_reg)
			rwcm_pkg::SQ_POR: begin
				if (!osc_ok) begin
					cnt_next = 12'h000;
				end else if (e_tick_i) begin
					cnt_next = cnt_reg + 12'h001;
					if (cnt_reg == `RWCM_POR_CYC - 12'h001) begin // R9
						st_next = pin_low ? rwcm_pkg::SQ_HOLD : rwcm_pkg::SQ_RUN;
					end
				end
			end
			rwcm_pkg::SQ_DRIVE: begin
				if (e_tick_i) begin
					cnt_next = cnt_reg + 12'h001;
					if (cnt_reg == `RWCM_DRIVE_CYC - 12'h001) begin // R10
						st_next = rwcm_pkg::SQ_SETTLE;
						cnt_next = 12'h000;
					end
				end
			end
			// The pin synchroniser lags two edges, so the decision waits one
			// more tick; otherwise the drive-low level still in the flops
			// would make every internal reset look external.
			rwcm_pkg::SQ_SETTLE: begin
				if (e_tick_i) begin
					cnt_next = cnt_reg + 12'h001;
					if (cnt_reg == `RWCM_SETTLE_CYC) begin // R11
						if (pin_low) begin
							st_next = rwcm_pkg::SQ_HOLD;
							cause_next = rwcm_pkg::CS_EXT;
						end else begin
							st_next = rwcm_pkg::SQ_RUN;
						end
					end
				end
			end
			rwcm_pkg::SQ_HOLD: begin
				if (!pin_low) begin
					st_next = rwcm_pkg::SQ_RUN;
				end
			end
			rwcm_pkg::SQ_RUN: begin
				cnt_next = 12'h000;
				if (pin_low | wd_fire | cm_fire) begin // R8
					st_next = rwcm_pkg::SQ_DRIVE;
				end
				if (pin_low) begin
					cause_next = rwcm_pkg::CS_EXT;
				end else if (wd_fire) begin
					cause_next = rwcm_pkg::CS_WDOG;
				end else if (cm_fire) begin
					cause_next = rwcm_pkg::CS_CM;
				end
			end
			default: begin
				st_next = rwcm_pkg::SQ_POR;
				cnt_next = 12'h000;
			end
		endcase
	end

	// Clock halt and restart; delay length picked by the delay enable bit
	wire [11:0] exit_len = dly_reg ? `RWCM_STOP_CYC : `RWCM_FAST_CYC; // R4
	always_comb begin
		hs_next = hs_reg;
		hcnt_next = hcnt_reg;
		unique case (hs_reg)
			rwcm_pkg::HS_RUN: begin
				hcnt_next = 12'h000;
				if (halt_req_i & running) begin
					hs_next = rwcm_pkg::HS_HALT;
				end
			end
			rwcm_pkg::HS_HALT: begin
				if (wake) begin
					hs_next = rwcm_pkg::HS_EXIT;
				end
			end
			rwcm_pkg::HS_EXIT: begin
				if (e_tick_i) begin
					hcnt_next = hcnt_reg + 12'h001;
					if (hcnt_reg == exit_len - 12'h001) begin // R4
						hs_next = rwcm_pkg::HS_RUN;
					end
				end
			end
			default: begin
				hs_next = rwcm_pkg::HS_RUN;
			end
		endcase
	end

	// Watchdog, monitor and window counters
	always_comb begin
		pre_next = tick ? pre_reg + 15'h0001 : pre_reg;
		div_next = pre_wrap ? div_reg + 6'h01 : div_reg;
		if (in_rst | svc_clear | wd_fire) begin // R16 R13
			pre_next = 15'h0000;
			div_next = 6'h00;
		end
		gap_next = (tick | ~cme_reg | in_rst) ? 16'h0000 : gap_reg + 16'h0001;
		win_next = in_rst ? 7'h00 : win_reg + {6'h00, tick & win_open};
	end

	// Vector select: cause and mode pick one of six addresses
	logic [15:0] vec_sel;
	always_comb begin
		unique case (cause_next) // R21 R24
			rwcm_pkg::CS_CM: vec_sel = special_reg ? `RWCM_VEC_CM_S : `RWCM_VEC_CM_N;
			rwcm_pkg::CS_WDOG: vec_sel = special_reg ? `RWCM_VEC_WD_S : `RWCM_VEC_WD_N;
			default: vec_sel = special_reg ? `RWCM_VEC_EXT_S : `RWCM_VEC_EXT_N;
		endcase
	end

	// Read mux; unimplemented and unmapped bits read zero
	wire [7:0] opt_rd = {2'h0, irq_edge_select_reg, dly_reg, cme_reg, 1'b0, rate_reg}; // R2
	logic [7:0] rd_sel;
	always_comb begin
		unique case (req_i.addr)
			`RWCM_OFS_OPTION: rd_sel = opt_rd;
			`RWCM_OFS_STATUS: rd_sel = {4'h0, win_open, special_reg, cause_reg};
			`RWCM_OFS_TEST: rd_sel = {7'h00, disable_resets_reg};
			`RWCM_OFS_CONFIG: rd_sel = {5'h00, nowd_reg, 2'h0};
			default: rd_sel = 8'h00;
		endcase
	end

	// Interrupt: level passes through, edge mode latches a falling edge
	logic irq_prev_reg;
	wire irq_fall = irq_low & ~irq_prev_reg;
	wire irq_req = irq_edge_select_reg ? irq_pend_reg : irq_low; // R3

	// Sequencer, counters and outputs
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= rwcm_pkg::SQ_POR;
			cause_reg <= rwcm_pkg::CS_EXT;
			hs_reg <= rwcm_pkg::HS_RUN;
			cnt_reg <= 12'h000;
			hcnt_reg <= 12'h000;
			pre_reg <= 15'h0000;
			div_reg <= 6'h00;
			gap_reg <= 16'h0000;
			win_reg <= 7'h00;
			rdata_o <= 8'h00;
			rst_pin_oe_o <= 1'b0;
			cpu_reset_o <= 1'b1;
			vector_o <= `RWCM_VEC_EXT_N;
			halted_o <= 1'b0;
			irq_req_o <= 1'b0;
		end else begin
			st_reg <= st_next;
			cause_reg <= cause_next;
			hs_reg <= in_rst ? rwcm_pkg::HS_RUN : hs_next;
			cnt_reg <= cnt_next;
			hcnt_reg <= hcnt_next;
			pre_reg <= pre_next;
			div_reg <= div_next;
			gap_reg <= gap_next;
			win_reg <= win_next;
			rdata_o <= req_i.rd ? rd_sel : 8'h00;
			rst_pin_oe_o <= (st_next == rwcm_pkg::SQ_DRIVE); // R10
			cpu_reset_o <= (st_next != rwcm_pkg::SQ_RUN); // R21
			vector_o <= vec_sel;
			halted_o <= (hs_next != rwcm_pkg::HS_RUN) & ~in_rst;
			irq_req_o <= irq_req;
		end
	end
	assign rst_pin_o = 1'b0;

	// Control registers; every reset sequence reloads them, mode taken
	// from the strap while reset is held
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			special_reg <= 1'b0;
			irq_edge_select_reg <= 1'b0;
			dly_reg <= 1'b1;
			cme_reg <= 1'b0;
			rate_reg <= 2'h0;
			nowd_reg <= 1'b0;
			disable_resets_reg <= 1'b0;
			opt_once_reg <= 1'b0;
			cfg_once_reg <= 1'b0;
			armed_reg <= 1'b0;
			svc_reg <= 8'h00;
		end else if (in_rst) begin
			special_reg <= strap_special;
			irq_edge_select_reg <= 1'b0;
			dly_reg <= 1'b1; // R23
			cme_reg <= 1'b0; // R23
			rate_reg <= 2'h0; // R7
			nowd_reg <= strap_special; // R14
			disable_resets_reg <= strap_special; // R15
			opt_once_reg <= 1'b0;
			cfg_once_reg <= 1'b0;
			armed_reg <= 1'b0;
			svc_reg <= 8'h00; // R22
		end else begin
			if (wr_opt) begin
				cme_reg <= req_i.wdata[`RWCM_B_CME]; // R5
				opt_once_reg <= 1'b1;
			end
			if (wr_opt & opt_prot_ok) begin // R1
				irq_edge_select_reg <= req_i.wdata[`RWCM_B_IRQ_EDGE_SELECT];
				dly_reg <= req_i.wdata[`RWCM_B_DLY];
				rate_reg <= req_i.wdata[1:0];
			end
			if (wr_cfg) begin
				cfg_once_reg <= 1'b1;
			end
			if (wr_cfg & cfg_prot_ok) begin // R14
				nowd_reg <= req_i.wdata[`RWCM_B_NOWD];
			end
			if (wr_test & special_reg) begin // R15
				disable_resets_reg <= req_i.wdata[`RWCM_B_DISABLE_RESETS];
			end
			if (wr_svc) begin
				svc_reg <= req_i.wdata;
			end
			if (svc_arm) begin // R16
				armed_reg <= 1'b1;
			end else if (svc_clear) begin
				armed_reg <= 1'b0;
			end
		end
	end

	// Edge latch; a new edge in the acknowledge cycle wins
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_prev_reg <= 1'b0;
			irq_pend_reg <= 1'b0;
		end else begin
			irq_prev_reg <= irq_low;
			irq_pend_reg <= irq_fall | (irq_pend_reg & ~irq_ack_i & irq_edge_select_reg); // R3
		end
	end

	// E ticks seen while the pin is driven, for the drive length check
	logic [11:0] drv_ticks_reg;
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			drv_ticks_reg <= 12'h000;
		end else if (rst_pin_oe_o) begin
			drv_ticks_reg <= drv_ticks_reg + {11'h000, e_tick_i};
		end else begin
			drv_ticks_reg <= 12'h000;
		end
	end

	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	a_pin_drive_len: assert property ( // R10
		$fell(rst_pin_oe_o) |-> drv_ticks_reg == `RWCM_DRIVE_CYC)
		else $error("reset pin drive length wrong");
	a_opt_reserved: assert property ( // R2
		req_i.rd && req_i.addr == `RWCM_OFS_OPTION |=> rdata_o[7:6] == 2'h0 && !rdata_o[2])
		else $error("reserved option bits not zero");
	a_prot_locked: assert property ( // R1
		running && !special_reg && !win_open && wr_opt |=> $stable(rate_reg) && $stable(dly_reg))
		else $error("protected bit changed after window");
	a_rate_reset: assert property ( // R7
		$rose(running) |-> rate_reg == 2'h0 && dly_reg && !cme_reg)
		else $error("option reset values wrong");
	a_unarmed_clear: assert property ( // R25
		wr_svc && req_i.wdata == `RWCM_CLEAR_CODE && !armed_reg && running && !tick
		|=> pre_reg == $past(pre_reg))
		else $error("unarmed clear touched the watchdog");
	a_cm_disabled: assert property ( // R5
		running && !cme_reg && !pin_low && !wd_fire |=> st_reg == rwcm_pkg::SQ_RUN)
		else $error("monitor reset while disabled");
	a_vector_wdog: assert property ( // R24
		$rose(cpu_reset_o) && cause_reg == rwcm_pkg::CS_WDOG && !special_reg
		|-> vector_o == `RWCM_VEC_WD_N)
		else $error("watchdog vector wrong");
	a_wd_fire_reset: assert property ( // R13
		wd_fire |=> cpu_reset_o && rst_pin_oe_o)
		else $error("watchdog timeout did not reset");
	a_irq_level: assert property ( // R3
		!irq_edge_select_reg && !$past(irq_edge_select_reg) |-> irq_req_o == $past(irq_low))
		else $error("level interrupt not followed");
	c_wdog_reset: cover property (wd_fire);
	c_cm_reset: cover property (cm_fire);
	c_ext_hold: cover property (st_reg == rwcm_pkg::SQ_HOLD);
	c_stop_exit: cover property (hs_reg == rwcm_pkg::HS_EXIT ##1 hs_reg == rwcm_pkg::HS_RUN);
endmodule : rwcm_top

// [dv/rwcm_rst_ckt.sv]
`timescale 1ns/1ps
// External reset circuit on the open-drain reset line, with a pull-up
module rwcm_rst_ckt (
	input wire logic clk_i, // System clock
	input wire logic drv_i, // Device drive value
	input wire logic drv_oe_i, // Device drives the line
	input wire logic hold_i, // Circuit holds the line low
	input wire logic slow_i, // Late rise after the device lets go
	output logic pin_o // Resolved line level
);
	logic [3:0] lag_reg = 4'h0;
	// Slow mode stretches the low level after release, like an RC delay would
	always_ff @(posedge clk_i) begin
		if (drv_oe_i && slow_i)
			lag_reg <= 4'hC;
		else if (lag_reg != 4'h0)
			lag_reg <= lag_reg - 4'h1;
	end
	// Pull-up wins as soon as nobody pulls low: a prompt rise
	assign pin_o = !((drv_oe_i && !drv_i) || hold_i || (lag_reg != 4'h0));
endmodule : rwcm_rst_ckt

// [dv/rwcm_top_tb.sv]
`timescale 1ns/1ps
module rwcm_top_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	rwcm_pkg::rwcm_req_t req = '0;
	logic [7:0] rdata;
	logic tick_en = 1'b1;
	logic e_tick = 1'b0;
	logic osc_ok = 1'b0;
	logic irq_n = 1'b1;
	logic irq_ack = 1'b0;
	logic halt_req = 1'b0;
	logic wake = 1'b0;
	logic hold = 1'b1;
	logic slow = 1'b0;
	logic pin, pin_drv, pin_oe, irq_req, halted, cpu_rst;
	logic [15:0] vec;
	int num_errors = 0;
	int n_checks = 0;
	int n, opt_m, once_m;

	// Clock and one E tick per cycle; gaps in the ticks stand for a stopped clock
	initial forever #4 clk = ~clk;
	always @(posedge clk) e_tick <= tick_en;

	rwcm_top #(.CM_GAP_CYC(20)) i_dut (.sys_clk_i(clk), .rst_i(rst), .req_i(req),
		.rdata_o(rdata), .e_tick_i(e_tick), .osc_ok_i(osc_ok), .mode_special_i(1'b0),
		.rst_pin_i(pin), .rst_pin_o(pin_drv), .rst_pin_oe_o(pin_oe), .irq_n_i(irq_n),
		.irq_ack_i(irq_ack), .irq_req_o(irq_req), .halt_req_i(halt_req), .wake_i(wake),
		.halted_o(halted), .cpu_reset_o(cpu_rst), .vector_o(vec));
	rwcm_rst_ckt i_ckt (.clk_i(clk), .drv_i(pin_drv), .drv_oe_i(pin_oe), .hold_i(hold),
		.slow_i(slow), .pin_o(pin));

	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Register write; the option mirror follows the once-only protection
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) req.wr <= 1'b0;
		if (a == 8'h39) begin
			opt_m = once_m ? ((opt_m & 8'h33) | (d & 8'h08)) : (d & 8'h3B);
			once_m = 1;
		end
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] msk,
		input logic [7:0] exp);
		@(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) req.rd <= 1'b0;
		#1 chk(what, {8'h00, exp}, {8'h00, rdata & msk});
	endtask : chk_reg

	// Bounded wait; edge updates land before the level is looked at
	task automatic wait_sig(ref logic s, input logic lvl, input int lim);
		n = 0;
		#1;
		while (s !== lvl && n < lim) begin
			@(posedge clk);
			#1 n++;
		end
	endtask : wait_sig

	task automatic halt_go;
		@(posedge clk) halt_req <= 1'b1;
		@(posedge clk) halt_req <= 1'b0;
	endtask : halt_go

	task automatic model_reset;
		opt_m = 8'h10;
		once_m = 0;
	endtask : model_reset

	// Whole run is about 41000 cycles; this limit leaves ample margin
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		complete_run();
	end

	initial begin
		void'($urandom(32'h961D));
		model_reset();
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		osc_ok <= 1'b1;
		repeat (4050) @(posedge clk);
		#1 chk("por_wait", 1'b1, cpu_rst);
		repeat (100) @(posedge clk);
		chk("pin_low_hold", 1'b1, cpu_rst);
		hold <= 1'b0;
		wait_sig(cpu_rst, 1'b0, 20);
		chk("por_run", 1'b0, cpu_rst);
		chk("vec_ext", 16'hFFFE, vec);
		chk_reg("opt_rst", 8'h39, 8'hFF, 8'h10);
		chk_reg("svc_rst", 8'h3A, 8'hFF, 8'h00);
		wr(8'h39, 8'hFF);
		chk_reg("opt_first", 8'h39, 8'hFF, opt_m[7:0]);
		wr(8'h39, 8'h00);
		chk_reg("opt_second", 8'h39, 8'hFF, opt_m[7:0]);
		wr(8'h30, 8'($urandom));
		chk_reg("opt_unmapped", 8'h39, 8'hFF, opt_m[7:0]);
		$display("test config done");
		// Edge mode: acknowledge clears though the line stays low
		irq_n <= 1'b0;
		repeat (5) @(posedge clk);
		#1 chk("irq_edge", 1'b1, irq_req);
		@(posedge clk) irq_ack <= 1'b1;
		@(posedge clk) irq_ack <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk("irq_ack", 1'b0, irq_req);
		irq_n <= 1'b1;
		$display("test irq done");
		// Stopped clock: ignored with the monitor off, reset with it on
		tick_en <= 1'b0;
		repeat (40) @(posedge clk);
		tick_en <= 1'b1;
		#1 chk("cm_off", 1'b0, cpu_rst);
		wr(8'h39, 8'h08);
		chk_reg("opt_cme", 8'h39, 8'hFF, opt_m[7:0]);
		tick_en <= 1'b0;
		wait_sig(cpu_rst, 1'b1, 40);
		tick_en <= 1'b1;
		chk("cm_fire", 1'b1, cpu_rst);
		chk("vec_cm", 16'hFFFC, vec);
		wait_sig(pin_oe, 1'b0, 20);
		chk("drive_len", 1'b1, 16'(n >= 4 && n <= 7));
		wait_sig(cpu_rst, 1'b0, 20);
		chk_reg("cause_cm", 8'h3B, 8'h03, 8'h01);
		model_reset();
		chk_reg("opt_reload", 8'h39, 8'hFF, opt_m[7:0]);
		$display("test monitor done");
		// Short exit from halt with the delay bit cleared, monitor off first
		wr(8'h39, 8'h00);
		halt_go();
		#1 chk("halt_on", 1'b1, halted);
		wake <= 1'b1;
		wait_sig(halted, 1'b0, 20);
		chk("halt_fast", 1'b0, halted);
		wake <= 1'b0;
		// Halt with the monitor on, line rising late: read as external
		wr(8'h39, 8'h08);
		slow <= 1'b1;
		halt_go();
		wait_sig(cpu_rst, 1'b1, 40);
		chk("cm_halt", 1'b1, cpu_rst);
		chk("vec_halt", 16'hFFFC, vec);
		wait_sig(cpu_rst, 1'b0, 60);
		slow <= 1'b0;
		chk_reg("cause_slow", 8'h3B, 8'h03, 8'h00);
		model_reset();
		// Long exit from halt after reset restored the delay bit
		halt_go();
		wake <= 1'b1;
		repeat (3900) @(posedge clk);
		#1 chk("halt_slow", 1'b1, halted);
		wait_sig(halted, 1'b0, 200);
		chk("halt_end", 1'b0, halted);
		wake <= 1'b0;
		$display("test halt done");
		// Service with a stray write between; a later unarmed clear is ignored
		wr(8'h3A, 8'h55);
		wr(8'h3A, {4'h1, 4'($urandom)});
		wr(8'h3A, 8'hAA);
		repeat (20000) @(posedge clk);
		wr(8'h3A, 8'hAA);
		repeat (12700) @(posedge clk);
		#1 chk("wd_early", 1'b0, cpu_rst);
		wait_sig(cpu_rst, 1'b1, 150);
		chk("wd_fire", 1'b1, cpu_rst);
		chk("vec_wd", 16'hFFFA, vec);
		wait_sig(cpu_rst, 1'b0, 30);
		chk_reg("cause_wd", 8'h3B, 8'h03, 8'h02);
		$display("test watchdog done");
		complete_run();
	end
endmodule : rwcm_top_tb
